/* File: verilog/fepa_core.sv */
// digital core of a 10/100 transceiver: straps, nibble paths, jabber, autoneg
// assumes straps and MAC pins are asynchronous, front-end inputs are on clk_in
`default_nettype none
// What this block does
// R1: latch station address from shared pins
// R2: latch loopback, serial, isolate, reduced modes
// R3: speed strap sets control bit 13, advertisement
// R4: fiber with speed low disables far-end fault
// R5: duplex strap sets control bit 8, advertisement
// R6: autoneg strap sets control bit 12
// R7: power-down input low powers the device down
// R8: sample nibbles on link clock rise, serialise
// R9: serial stream NRZ to NRZI
// R10: receive NRZI to NRZ nibbles, falling edge
// R11: keep transmit and receive clocks running
// R12: 10 Mb/s transmit follows transmit enable
// R13: final Manchester transition by last bit
// R14: squelch and lock give carrier, valid, data
// R15: receive clock runs between 10 Mb/s frames
// R16: collision pulse after each 10 Mb/s frame
// R17: jabber cut-off and long-quiet re-enable
// R18: autoneg by strap or bit, off in fiber
// R19: send advertisement bursts on start events
// R20: parallel detect sets speed from signalling
// R21: resolve common mode by fixed priority
// R22: two sets of three identical words
module fepa_core #(
  parameter int unsigned JABBER_CYC   = fepa_pkg::JABBER_CYC,
  parameter int unsigned REENABLE_CYC = fepa_pkg::REENABLE_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic [13:0] strap_in,
  input  wire logic        power_down_n_in,
  input  wire logic        mii_clk_in,
  input  wire logic        tx_en_in,
  input  wire logic [3:0]  txd_in,
  output logic             rx_clk_out,
  output logic [3:0]       rxd_out,
  output logic             rx_dv_out,
  output logic             crs_out,
  output logic             col_out,
  output logic             mii_oe_out,
  output logic             tx_line_out,
  output logic             tx_active_out,
  input  wire logic        rx_bit_in,
  input  wire logic        rx_bit_en_in,
  input  wire logic        squelch_ok_in,
  input  wire logic        rx_lock_in,
  input  wire logic        link_ok_in,
  input  wire logic [15:0] lcw_in,
  input  wire logic        lcw_valid_in,
  input  wire logic        nlp_seen_in,
  input  wire logic        idle100_seen_in,
  output logic             flp_send_out,
  output logic [15:0]      flp_word_out,
  output logic             speed_100_out,
  output logic             full_duplex_out,
  output logic [4:0]       station_address_out,
  output logic [4:0]       mode_select_out,
  output logic             far_end_fault_en_out,
  output logic             powered_down_out
);
  fepa_pkg::fepa_straps_t strap_q;
  fepa_pkg::fepa_straps_t straps;
  fepa_pkg::fepa_mii_tx_t mii_q;
  fepa_pkg::fepa_an_state_t an_state;
  logic [2:0]  strap_wait;
  logic        strap_done;
  logic        strap_take;
  logic [15:0] ctrl;
  logic [15:0] adv;
  logic [15:0] partner;
  logic        pd_q;
  logic        clk_d;
  logic        clk_rise;
  logic        clk_fall;
  logic        ten_mode;
  logic        an_enabled;
  logic        an_start;
  logic        link_d;
  logic        tx_en_d;
  logic [3:0]  tx_nib;
  logic [2:0]  phase;
  logic        shifting;
  logic        cur_bit;
  logic        tx_nrzi;
  logic        rx_prev;
  logic [3:0]  rx_shift;
  logic [3:0]  rx_hold;
  logic        rx_nrz;
  logic [1:0]  rx_cnt;
  logic        rx_full;
  logic        line_active;
  logic        jabbered;
  logic [22:0] jab_cnt;
  logic [7:0]  sqe_cnt;
  logic        sqe_on;
  logic [15:0] lcw_last;
  logic [1:0]  lcw_cnt;
  logic        lcw_hit;
  logic [3:0]  common;

  // code word with the acknowledge bit cleared, for matching
  function automatic logic [15:0] strip_ack(input logic [15:0] w);
    strip_ack = w & ~(16'h0001 << fepa_pkg::LCW_ACK);
  endfunction

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // pin synchronisers for straps, power-down and MAC transmit pins
  fepa_sync3 #(.W(fepa_pkg::STRAP_W + 1)) u_strap_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    ({strap_in, power_down_n_in}),
    .q_out   ({strap_q, pd_q})
  );
  fepa_sync3 #(.W(6)) u_mii_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    ({mii_clk_in, tx_en_in, txd_in}),
    .q_out   (mii_q)
  );

  // straps are taken once the synchroniser has settled after release
  assign strap_take = !strap_done && (strap_wait == 3'h0);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_wait <= fepa_pkg::STRAP_WAIT;
      strap_done <= 1'b0;
      straps     <= '0;
    end else if (strap_take) begin
      strap_done <= 1'b1;
      straps     <= strap_q; // [R1] [R2]
    end else if (!strap_done) begin
      strap_wait <= strap_wait - 3'h1;
    end
  end
  addr_latch_a: assert property (strap_take |=> station_address_out == $past(strap_q.addr)); // [R1]
  mode_latch_a: assert property (strap_take |=> mode_select_out[4] == $past(strap_q.loopback)
                                  && mode_select_out[2] == $past(strap_q.isolate)); // [R2]

  assign station_address_out  = straps.addr;
  assign mode_select_out      = {straps.loopback, straps.serial, straps.isolate,
                                 straps.reduced, straps.btb};
  assign far_end_fault_en_out = !(straps.fiber && !straps.speed); // [R4]
  assign powered_down_out     = !pd_q; // [R7]
  assign mii_oe_out           = strap_done && !straps.isolate && pd_q;

  // control register: strap values at release, software writes after
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= fepa_pkg::CTRL_RST;
    end else if (strap_take) begin
      ctrl[fepa_pkg::CTRL_SPEED]  <= strap_q.speed;   // [R3]
      ctrl[fepa_pkg::CTRL_DUPLEX] <= strap_q.duplex;  // [R5]
      ctrl[fepa_pkg::CTRL_AN_EN]  <= strap_q.autoneg; // [R6]
    end else if (wr_in && addr_in == fepa_pkg::REG_CTRL) begin
      ctrl[fepa_pkg::CTRL_SPEED]   <= wdata_in[fepa_pkg::CTRL_SPEED];
      ctrl[fepa_pkg::CTRL_DUPLEX]  <= wdata_in[fepa_pkg::CTRL_DUPLEX];
      ctrl[fepa_pkg::CTRL_AN_EN]   <= wdata_in[fepa_pkg::CTRL_AN_EN]; // [R18]
      ctrl[fepa_pkg::CTRL_RESTART] <= wdata_in[fepa_pkg::CTRL_RESTART];
    end else if (an_state == fepa_pkg::AN_SEND) begin
      ctrl[fepa_pkg::CTRL_RESTART] <= 1'b0; // restart taken
    end
  end
  speed_latch_a: assert property (strap_take |=> ctrl[fepa_pkg::CTRL_SPEED] == $past(strap_q.speed)
                                   && adv[fepa_pkg::ABIL_100HD] == $past(strap_q.speed)); // [R3]
  dup_latch_a: assert property (strap_take |=> ctrl[fepa_pkg::CTRL_DUPLEX] == $past(strap_q.duplex)
                                 && adv[fepa_pkg::ABIL_10FD] == $past(strap_q.duplex)); // [R5]
  an_latch_a: assert property (strap_take |=> ctrl[fepa_pkg::CTRL_AN_EN] == $past(strap_q.autoneg)); // [R6]

  // advertisement register seeded from speed and duplex straps
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adv <= fepa_pkg::ADV_BASE;
    end else if (strap_take) begin
      adv                     <= fepa_pkg::ADV_BASE;
      adv[fepa_pkg::ABIL_100FD] <= strap_q.speed && strap_q.duplex; // [R3] [R5]
      adv[fepa_pkg::ABIL_100HD] <= strap_q.speed;
      adv[fepa_pkg::ABIL_10FD]  <= strap_q.duplex;
      adv[fepa_pkg::ABIL_10HD]  <= 1'b1;
    end else if (wr_in && addr_in == fepa_pkg::REG_ADV) begin
      adv[8:5] <= wdata_in[8:5];
    end
  end

  // read data stand in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        fepa_pkg::REG_CTRL:    rdata_out <= ctrl;
        fepa_pkg::REG_STAT:    rdata_out <= {10'h000, an_state == fepa_pkg::AN_DONE,
                                             2'h0, link_ok_in, 2'h0};
        fepa_pkg::REG_ADV:     rdata_out <= adv;
        fepa_pkg::REG_PARTNER: rdata_out <= partner;
        fepa_pkg::REG_STRAP:   rdata_out <= {pd_q, !far_end_fault_en_out, straps.fiber,
                                             mode_select_out, 3'h0, straps.addr};
        default:               rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  // link clock edges, found by sampling the synchronised nibble clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= mii_q.clk;
    end
  end
  assign clk_rise   = mii_q.clk && !clk_d;
  assign clk_fall   = !mii_q.clk && clk_d;
  assign rx_clk_out = clk_d; // [R11] [R15]
  assign ten_mode   = !speed_100_out;

  // nibble taken on link clock rise, then eight half-bit phases
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_nib   <= 4'h0;
      phase    <= 3'h0;
      shifting <= 1'b0;
    end else if (clk_rise && mii_q.en && !jabbered && pd_q) begin
      tx_nib   <= mii_q.data; // [R8] [R12]
      phase    <= 3'h0;
      shifting <= 1'b1;
    end else if (shifting) begin
      phase    <= phase + 3'h1;
      shifting <= (phase != 3'h7) && !jabbered; // jabber cuts a nibble short [R17]
    end
  end
  assign cur_bit       = tx_nib[phase[2:1]];
  assign tx_active_out = shifting && !jabbered; // [R17]

  // NRZI toggles on each one; Manchester holds high after the frame
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_nrzi     <= 1'b0;
      tx_line_out <= 1'b1;
    end else if (shifting && ten_mode) begin
      tx_line_out <= phase[0] ? cur_bit : !cur_bit; // [R12] [R13]
    end else if (shifting) begin
      if (!phase[0] && cur_bit) begin
        tx_nrzi <= !tx_nrzi; // [R9]
      end
      tx_line_out <= (!phase[0] && cur_bit) ? !tx_nrzi : tx_nrzi;
    end else if (ten_mode) begin
      tx_line_out <= 1'b1; // [R13]
    end
  end
  nrzi_a: assert property (shifting && !ten_mode && !phase[0] && cur_bit
                           |=> tx_line_out != $past(tx_nrzi)); // [R9]
  man_end_a: assert property (!shifting && $past(shifting) && ten_mode |=> tx_line_out); // [R13]

  // receive: NRZI decode in 100 mode, deserialise into nibbles
  assign line_active = ten_mode ? (squelch_ok_in && rx_lock_in) : rx_lock_in; // [R14]
  assign rx_nrz      = ten_mode ? rx_bit_in : (rx_bit_in ^ rx_prev); // [R10]
  // a whole nibble is held until the next link clock fall hands it over
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_prev  <= 1'b0;
      rx_shift <= 4'h0;
      rx_hold  <= 4'h0;
      rx_cnt   <= 2'h0;
      rx_full  <= 1'b0;
    end else if (!line_active) begin
      rx_cnt  <= 2'h0;
      rx_full <= 1'b0;
    end else if (rx_bit_en_in) begin
      rx_prev  <= rx_bit_in;
      rx_shift <= {rx_nrz, rx_shift[3:1]};
      rx_cnt   <= rx_cnt + 2'h1;
      if (rx_cnt == 2'h3) begin
        rx_hold <= {rx_nrz, rx_shift[3:1]}; // completion wins over the fall
        rx_full <= 1'b1;
      end else if (clk_fall) begin
        rx_full <= 1'b0;
      end
    end else if (clk_fall) begin
      rx_full <= 1'b0;
    end
  end

  // nibble and valid change on the falling link clock edge only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rxd_out   <= 4'h0;
      rx_dv_out <= 1'b0;
      crs_out   <= 1'b0;
    end else if (clk_fall) begin
      rxd_out   <= rx_hold; // [R10]
      rx_dv_out <= line_active && (rx_full || rx_dv_out); // [R14]
      crs_out   <= line_active;
    end
  end
  rx_edge_a: assert property (rxd_out != $past(rxd_out) |-> $past(clk_fall)); // [R10]

  // 10 Mb/s jabber watchdog: long enable cuts the transmitter, long quiet restores
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      jab_cnt  <= 23'h00_0000;
      jabbered <= 1'b0;
    end else if (!ten_mode) begin
      jab_cnt  <= 23'h00_0000;
      jabbered <= 1'b0;
    end else if (!jabbered) begin
      jab_cnt  <= mii_q.en ? jab_cnt + 23'h00_0001 : 23'h00_0000;
      jabbered <= mii_q.en && (jab_cnt >= JABBER_CYC[22:0]); // [R17]
      if (mii_q.en && (jab_cnt >= JABBER_CYC[22:0])) begin
        jab_cnt <= 23'h00_0000;
      end
    end else begin
      jab_cnt  <= mii_q.en ? 23'h00_0000 : jab_cnt + 23'h00_0001;
      jabbered <= !(!mii_q.en && (jab_cnt >= REENABLE_CYC[22:0])); // [R17]
    end
  end
  jabber_a: assert property (jabbered |-> col_out && !tx_active_out ##1 1); // [R17]

  // signal-quality pulse after each 10 Mb/s frame
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_en_d <= 1'b0;
      sqe_cnt <= 8'h00;
    end else begin
      tx_en_d <= mii_q.en;
      if (tx_en_d && !mii_q.en && ten_mode && !jabbered) begin
        sqe_cnt <= fepa_pkg::SQE_CYC[7:0]; // [R16]
      end else if (sqe_cnt != 8'h00) begin
        sqe_cnt <= sqe_cnt - 8'h01;
      end
    end
  end
  assign sqe_on  = (sqe_cnt != 8'h00);
  assign col_out = jabbered || sqe_on || (!full_duplex_out && shifting && crs_out); // [R16]
  sequence frame_end_s;
    tx_en_d && !mii_q.en && ten_mode && !jabbered;
  endsequence
  sequence sqe_pulse_s;
    col_out [*8];
  endsequence
  sqe_a: assert property (frame_end_s |=> sqe_pulse_s); // [R16]

  // autonegotiation: start on power-on, link loss, restart; two sets of three
  assign an_enabled = ctrl[fepa_pkg::CTRL_AN_EN] && !straps.fiber; // [R18]
  assign an_start   = strap_done && an_enabled
                      && ((link_d && !link_ok_in) || ctrl[fepa_pkg::CTRL_RESTART]);
  assign lcw_hit    = lcw_valid_in && (strip_ack(lcw_in) == strip_ack(lcw_last));
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_d   <= 1'b0;
      lcw_last <= 16'h0000;
      lcw_cnt  <= 2'h0;
    end else begin
      link_d <= link_ok_in;
      if (lcw_valid_in) begin
        lcw_last <= lcw_in;
        lcw_cnt  <= lcw_hit ? ((lcw_cnt == fepa_pkg::LCW_SET) ? lcw_cnt : lcw_cnt + 2'h1)
                            : 2'h1;
      end else if (an_state == fepa_pkg::AN_CONFIRM && lcw_cnt == fepa_pkg::LCW_SET) begin
        lcw_cnt <= 2'h0; // second set counts afresh
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      an_state <= fepa_pkg::AN_IDLE;
      partner  <= 16'h0000;
    end else if (!an_enabled) begin
      an_state <= fepa_pkg::AN_IDLE;
    end else if (an_start) begin
      an_state <= fepa_pkg::AN_SEND; // [R19]
    end else begin
      case (an_state)
        fepa_pkg::AN_IDLE: begin
          if (strap_done) begin
            an_state <= fepa_pkg::AN_SEND; // power-on start [R19]
          end
        end
        fepa_pkg::AN_SEND: begin
          if (lcw_hit && lcw_cnt == 2'h2) begin
            partner  <= lcw_in; // [R22]
            an_state <= fepa_pkg::AN_CONFIRM;
          end else if (nlp_seen_in || idle100_seen_in) begin
            an_state <= fepa_pkg::AN_DONE; // [R20]
          end
        end
        fepa_pkg::AN_CONFIRM: begin
          if (lcw_hit && lcw_cnt == 2'h2) begin
            an_state <= fepa_pkg::AN_DONE; // [R22]
          end
        end
        fepa_pkg::AN_DONE: an_state <= fepa_pkg::AN_DONE;
        default: an_state <= fepa_pkg::AN_IDLE;
      endcase
    end
  end
  assign flp_send_out = an_state != fepa_pkg::AN_IDLE && an_state != fepa_pkg::AN_DONE; // [R19]
  assign flp_word_out = adv; // [R19]
  lcw_store_a: assert property (an_state == fepa_pkg::AN_SEND && lcw_hit && lcw_cnt == 2'h2
                                && an_enabled && !an_start |=> partner == $past(lcw_in)); // [R22]
  fiber_off_a: assert property (straps.fiber |-> !flp_send_out); // [R18]

  // resolved speed and duplex by fixed priority or parallel detect
  assign common = adv[8:5] & partner[8:5];
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      speed_100_out   <= 1'b0;
      full_duplex_out <= 1'b0;
    end else if (!an_enabled) begin
      speed_100_out   <= ctrl[fepa_pkg::CTRL_SPEED];
      full_duplex_out <= ctrl[fepa_pkg::CTRL_DUPLEX];
    end else if (an_state == fepa_pkg::AN_SEND && idle100_seen_in) begin
      speed_100_out   <= 1'b1; // [R20]
      full_duplex_out <= 1'b0;
    end else if (an_state == fepa_pkg::AN_SEND && nlp_seen_in) begin
      speed_100_out   <= 1'b0; // [R20]
      full_duplex_out <= 1'b0;
    end else if (an_state == fepa_pkg::AN_CONFIRM && lcw_hit && lcw_cnt == 2'h2) begin
      speed_100_out   <= common[3] || common[2]; // [R21]
      full_duplex_out <= common[3] || (!common[2] && common[1]);
    end
  end
  prio_a: assert property (an_state == fepa_pkg::AN_CONFIRM && lcw_hit && lcw_cnt == 2'h2
                           && an_enabled && !an_start && common[3]
                           |=> speed_100_out && full_duplex_out); // [R21]
endmodule
`default_nettype wire

/* File: verilog/fepa_pkg.sv */
// constants and carrier types for the 10/100 transceiver digital core
// assumes a 20 MHz core clock and a nibble clock sampled from a pin
`default_nettype none
package fepa_pkg;
  // core clock rate
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned CLK_KHZ        = 20000;
  // jabber limit and re-enable quiet time
  localparam int unsigned JABBER_MS      = 20;
  localparam int unsigned REENABLE_MS    = 250;
  localparam int unsigned JABBER_CYC     = JABBER_MS * CLK_KHZ;
  localparam int unsigned REENABLE_CYC   = REENABLE_MS * CLK_KHZ;
  // signal-quality pulse after each 10 Mb/s frame, least width
  localparam int unsigned SQE_NS         = 1000;
  localparam int unsigned SQE_CYC        = (SQE_NS * CLK_MHZ + 999) / 1000;
  // cycles spent after reset release before the straps are taken
  localparam logic [2:0]  STRAP_WAIT     = 3'h4;
  // register indices
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STAT       = 5'h01;
  localparam logic [4:0]  REG_ADV        = 5'h04;
  localparam logic [4:0]  REG_PARTNER    = 5'h05;
  localparam logic [4:0]  REG_STRAP      = 5'h1F;
  // control register fields
  localparam int unsigned CTRL_SPEED     = 13;
  localparam int unsigned CTRL_AN_EN     = 12;
  localparam int unsigned CTRL_RESTART   = 9;
  localparam int unsigned CTRL_DUPLEX    = 8;
  // status register fields
  localparam int unsigned STAT_AN_DONE   = 5;
  localparam int unsigned STAT_LINK      = 2;
  // advertisement / partner ability fields
  localparam int unsigned ABIL_100FD     = 8;
  localparam int unsigned ABIL_100HD     = 7;
  localparam int unsigned ABIL_10FD      = 6;
  localparam int unsigned ABIL_10HD      = 5;
  localparam int unsigned LCW_ACK        = 14;
  localparam logic [15:0] ADV_BASE       = 16'h0021;
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [1:0]  LCW_SET        = 2'h3;
  // strap values taken at reset release
  typedef struct packed {
    logic [4:0] addr;
    logic       loopback;
    logic       serial;
    logic       isolate;
    logic       reduced;
    logic       btb;
    logic       speed;
    logic       duplex;
    logic       autoneg;
    logic       fiber;
  } fepa_straps_t;
  localparam int unsigned STRAP_W = $bits(fepa_straps_t);
  // nibble side pins sampled from the MAC
  typedef struct packed {
    logic       clk;
    logic       en;
    logic [3:0] data;
  } fepa_mii_tx_t;
  typedef enum logic [1:0] { AN_IDLE, AN_SEND, AN_CONFIRM, AN_DONE } fepa_an_state_t;
endpackage
`default_nettype wire

/* File: verilog/fepa_sync3.sv */
// three-stage synchroniser for a group of pins
// assumes the inputs are asynchronous to clk_in
`default_nettype none
module fepa_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // a change is accepted once stages two and three agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_out <= '0;
    end else if (s2 == s3) begin
      q_out <= s3;
    end
  end
endmodule
`default_nettype wire

/* File: bench/fepa_mac_model.sv */
// mac-side model: free-running nibble link clock and transmit nibbles
// assumes the bench holds go_in high for as long as a frame should last
`default_nettype none
module fepa_mac_model (
  input  wire logic       go_in,
  input  wire logic [3:0] nib_in,
  output logic            mii_clk_out,
  output logic            tx_en_out,
  output logic [3:0]      txd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock runs free at 400 ns, phase unrelated to the core clock
  initial begin
    mii_clk_out = 1'b0;
    #37;
    forever #200 mii_clk_out = ~mii_clk_out;
  end
  // nibbles change on the fall so the sampling rise sees them settled
  initial begin
    tx_en_out = 1'b0;
    txd_out = 4'h0;
    forever begin
      @(negedge mii_clk_out);
      tx_en_out <= go_in;
      txd_out   <= go_in ? nib_in : ~txd_out; // released data keeps toggling
    end
  end
endmodule
`default_nettype wire

/* File: bench/fast_ethernet_phy_pcs_autoneg_tb_top.sv */
// self-checking bench for the transceiver core: straps, registers, autoneg, mac paths
// assumes fepa_core and fepa_mac_model are compiled before it
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module fast_ethernet_phy_pcs_autoneg_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0;
  logic        power_down_n_in = 1'b1, link_ok_in = 1'b1, go = 1'b0, seen_act = 1'b0;
  logic        rx_bit_in = 1'b0, rx_bit_en_in = 1'b0, squelch_ok_in = 1'b0, rx_lock_in = 1'b0;
  logic        lcw_valid_in = 1'b0, nlp_seen_in = 1'b0, idle100_seen_in = 1'b0;
  logic [4:0]  addr_in = 5'h00;
  logic [15:0] wdata_in = 16'h0000, lcw_in = 16'h0000, w, e_rd;
  logic [13:0] strap_in = 14'h020E;
  logic [9:0]  st;
  logic [3:0]  nib = 4'h0, ab, rx_nib;
  logic        mii_clk_in, tx_en_in, rx_clk_out, rx_dv_out, crs_out, col_out, mii_oe_out;
  logic        tx_line_out, tx_active_out, flp_send_out, speed_100_out, full_duplex_out;
  logic        far_end_fault_en_out, powered_down_out;
  logic [3:0]  txd_in, rxd_out;
  logic [15:0] rdata_out, flp_word_out;
  logic [4:0]  station_address_out, mode_select_out;
  logic [15:0] exp_q[$];
  int          miscompares = 0, total_checks = 0, seed = 32'h9e60, n;

  fepa_core #(.JABBER_CYC(40), .REENABLE_CYC(100)) DUT (
    .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .strap_in,
    .power_down_n_in, .mii_clk_in, .tx_en_in, .txd_in, .rx_clk_out, .rxd_out, .rx_dv_out,
    .crs_out, .col_out, .mii_oe_out, .tx_line_out, .tx_active_out, .rx_bit_in,
    .rx_bit_en_in, .squelch_ok_in, .rx_lock_in, .link_ok_in, .lcw_in, .lcw_valid_in,
    .nlp_seen_in, .idle100_seen_in, .flp_send_out, .flp_word_out, .speed_100_out,
    .full_duplex_out, .station_address_out, .mode_select_out, .far_end_fault_en_out,
    .powered_down_out);
  fepa_mac_model mac (.go_in(go), .nib_in(nib), .mii_clk_out(mii_clk_in),
    .tx_en_out(tx_en_in), .txd_out(txd_in));

  // core clock, 50 ns
  always #25 clk_in = ~clk_in;

  // read data is taken off the queue in the cycle after each read strobe
  always @(posedge clk_in) begin
    if (rd_q) begin
      e_rd = exp_q.pop_front();
      `CHK("rdata", e_rd, rdata_out)
    end
    rd_q <= rd_in;
    nib <= 4'($random(seed));
    if (tx_active_out === 1'b1) seen_act <= 1'b1;
  end

  // register bus cycles, one strobe each
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask
  // one-cycle front-end event: {idle100, nlp, code word}
  task automatic an_evt(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_in);
    {idle100_seen_in, nlp_seen_in, lcw_valid_in} <= s;
    lcw_in <= d;
    @(posedge clk_in);
    {idle100_seen_in, nlp_seen_in, lcw_valid_in} <= 3'h0;
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK("addr", 5'h01, station_address_out)
    `CHK("modes", 5'h00, mode_select_out)
    `CHK("fef", 1'b1, far_end_fault_en_out)
    `CHK("pd", 1'b0, powered_down_out)
    `CHK("flp", 1'b1, flp_send_out)
    `CHK("flp_word", 16'h01E1, flp_word_out)
    reg_rd(5'h00, 16'h3100);
    reg_rd(5'h04, 16'h01E1);
    reg_rd(5'h02, 16'h0000); // unmapped index
    // restart, then code words with mixed acks, or a parallel-detect event
    for (int i = 0; i < 6; i++) begin
      reg_wr(5'h00, 16'h3300);
      repeat (4) @(posedge clk_in);
      `CHK("flp_rs", 1'b1, flp_send_out)
      ab = (4'h8 >> i) | (4'($random(seed)) & ((4'h8 >> i) - 4'h1));
      w = 16'($random(seed));
      w[8:5] = ab;
      if (i < 4) begin
        for (int k = 0; k < 6; k++) begin
          w[14] = 1'($random(seed));
          an_evt(3'h1, w);
          if (k == 2) reg_rd(5'h05, w);
        end
      end else an_evt((i == 4) ? 3'h4 : 3'h2, 16'h0000);
      repeat (4) @(posedge clk_in);
      `CHK("speed", 1'(i < 2 || i == 4), speed_100_out)
      `CHK("duplex", 1'(i == 0 || i == 2), full_duplex_out)
      reg_rd(5'h01, 16'h0024);
    end
    // 10 Mb/s half duplex: short frame, then a jabbering one
    reg_wr(5'h00, 16'h0000);
    go <= 1'b1;
    repeat (24) @(posedge clk_in);
    go <= 1'b0;
    `CHK("tx_active", 1'b1, seen_act)
    for (n = 0; n < 60 && col_out !== 1'b1; n++) @(posedge clk_in);
    `CHK("sqe", 1'b1, col_out)
    for (n = 0; n < 60 && col_out !== 1'b0; n++) @(posedge clk_in);
    `CHK("sqe_end", 1'b0, col_out)
    `CHK("line_idle", 1'b1, tx_line_out)
    go <= 1'b1;
    repeat (120) @(posedge clk_in);
    `CHK("jab_col", 1'b1, col_out)
    `CHK("jab_tx", 1'b0, tx_active_out)
    go <= 1'b0;
    repeat (60) @(posedge clk_in);
    `CHK("quiet_col", 1'b1, col_out)
    for (n = 0; n < 200 && col_out !== 1'b0; n++) @(posedge clk_in);
    `CHK("reenable", 1'b0, col_out)
    // receive a repeated nibble, lsb first, one bit per two cycles
    rx_nib = 4'($random(seed));
    squelch_ok_in <= 1'b1;
    rx_lock_in <= 1'b1;
    for (n = 0; n < 80 && rx_dv_out !== 1'b1; n++) begin
      @(posedge clk_in);
      rx_bit_en_in <= ~n[0];
      rx_bit_in <= rx_nib[n[2:1]];
    end
    `CHK("rxd", rx_nib, rxd_out)
    `CHK("crs", 1'b1, crs_out)
    squelch_ok_in <= 1'b0;
    for (n = 0; n < 40 && rx_dv_out !== 1'b0; n++) @(posedge clk_in);
    `CHK("rx_dv_end", 1'b0, rx_dv_out)
    for (n = 0; n < 12 && rx_clk_out !== 1'b0; n++) @(posedge clk_in);
    `CHK("rx_clk_lo", 1'b0, rx_clk_out)
    for (n = 0; n < 12 && rx_clk_out !== 1'b1; n++) @(posedge clk_in);
    `CHK("rx_clk_hi", 1'b1, rx_clk_out)
    // short 100 Mb/s full duplex frame: NRZI path, no signal-quality pulse
    reg_wr(5'h00, 16'h2100);
    go <= 1'b1;
    repeat (24) @(posedge clk_in);
    go <= 1'b0;
    repeat (24) @(posedge clk_in);
    `CHK("no_sqe", 1'b0, col_out)
    // second reset: random address and modes, fiber on, speed strap low
    st = 10'($random(seed));
    nrst_in <= 1'b0;
    strap_in <= {st, 4'h7};
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK("addr2", st[9:5], station_address_out)
    `CHK("modes2", st[4:0], mode_select_out)
    `CHK("fef2", 1'b0, far_end_fault_en_out)
    `CHK("flp_fiber", 1'b0, flp_send_out)
    reg_rd(5'h04, 16'h0061);
    power_down_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK("pd_on", 1'b1, powered_down_out)
    `CHK("oe_off", 1'b0, mii_oe_out)
    tally_and_finish();
  end
endmodule
`default_nettype wire
